/* File: hdl/vira_defines.svh */
// Constants for the vectored interrupt arbiter: slots, opcodes, timing.
// Assumes inclusion by bare name from design files only.
`ifndef VIRA_DEFINES_SVH
`define VIRA_DEFINES_SVH

// Vector slot low bytes
`define VIRA_SLOT_TRAP 8'hFE
`define VIRA_SLOT_EXT 8'hFA
`define VIRA_SLOT_T0 8'hF8
`define VIRA_SLOT_T1A 8'hF6
`define VIRA_SLOT_T1B 8'hF4
`define VIRA_SLOT_SER 8'hF2
`define VIRA_SLOT_T2A 8'hEA
`define VIRA_SLOT_T2B 8'hE8
`define VIRA_SLOT_WAKE 8'hE2
`define VIRA_SLOT_DEFAULT 8'hE0

// Opcode and acknowledge target
`define VIRA_TRAP_OPCODE 8'h00
`define VIRA_ACK_PC 15'h00FF
// Acknowledge sequence length in instruction cycles
`define VIRA_ACK_CYCLES 3'h7
// Reset values
`define VIRA_RST_BYTE 8'h00
`define VIRA_RST_PC 15'h0000

`endif

/* File: hdl/vira_pkg.sv */
// Types for the vectored interrupt arbiter.
// Assumes nothing beyond a SystemVerilog compiler.
package vira_pkg;
	// Sequencer states, Gray coded along the usual path
	typedef enum logic [2:0] {
		vira_idle = 3'h0,
		vira_ack = 3'h4,
		vira_vec_hi = 3'h1,
		vira_vec_lo = 3'h3,
		vira_ret = 3'h2
	} vira_state_t;
endpackage

/* File: hdl/vira_edge_line.sv */
// One port-L wake line: edge detect and pending latch.
// Assumes the pin is synchronous to mclk_in.
`timescale 1ns/100ps
`default_nettype none
module vira_edge_line (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic pin_in,
	input wire logic falling_in,
	input wire logic clear_in,
	input wire logic hold_in,
	output logic pending_out
);
	logic last_pin;
	logic pending;
	logic armed;
	wire rise = pin_in & ~last_pin;
	wire fall = ~pin_in & last_pin;
	// No edge in the first cycle after reset: the pin's idle level is unknown
	wire hit = armed & (falling_in ? fall : rise);

	// ==========================================================
	// Edge latch
	// ==========================================================
	// Set wins over clear; repeats while held are simply absorbed
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_pin <= 1'b0;
			pending <= 1'b0;
			armed <= 1'b0;
		end else begin
			last_pin <= pin_in;
			armed <= 1'b1;
			if (hit) begin
				pending <= 1'b1;
			end else if (clear_in && !hold_in) begin
				pending <= 1'b0;
			end
		end
	end
	assign pending_out = pending;
endmodule
`default_nettype wire

/* File: hdl/vira_top.sv */
// Vectored interrupt arbiter: ranking, trap flag, port-L edges, acknowledge.
// Assumes the instruction sequencer drives one-cycle op strobes on mclk_in
// and returns program-memory bytes on pmem_data_in in the same cycle as the request.
`timescale 1ns/100ps
`default_nettype none
`include "vira_defines.svh"
module vira_top
	import vira_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// Instruction sequencer strobes
	input wire logic ir_load_in,
	input wire logic [7:0] ir_opcode_in,
	input wire logic [14:0] ir_addr_in,
	input wire logic [14:0] next_addr_in,
	input wire logic outside_flash_in,
	input wire logic vector_select_op_in,
	input wire logic clear_trap_pending_op_in,
	input wire logic return_enable_op_in,
	input wire logic [14:0] pop_addr_in,
	input wire logic set_gie_in,
	input wire logic clear_gie_in,
	input wire logic boot_rom_in,
	input wire logic halted_in,
	// Program counter and memory
	input wire logic [14:0] pc_in,
	input wire logic [7:0] pmem_data_in,
	// Maskable sources: pending and individual enable
	input wire logic [6:0] src_pending_in,
	input wire logic [6:0] src_enable_in,
	// Port L
	input wire logic [7:0] port_l_in,
	input wire logic [7:0] wake_line_enable_in,
	input wire logic [7:0] wake_edge_select_in,
	input wire logic [7:0] wake_line_clear_in,
	input wire logic wake_irq_global_enable_in,
	// Outputs
	output logic global_irq_enable_out,
	output logic trap_pending_flag_out,
	output logic [7:0] wake_line_pending_out,
	output logic irq_request_out,
	output logic ack_busy_out,
	output logic pc_load_out,
	output logic [14:0] pc_value_out,
	output logic pmem_req_out,
	output logic [14:0] pmem_addr_out,
	output logic push_out,
	output logic [14:0] push_addr_out,
	output logic trap_fetch_out,
	output logic wake_out,
	output logic resume_next_out
);
	vira_state_t state;
	vira_state_t next_state;
	logic [2:0] ack_count;
	logic global_irq_enable;
	logic trap_pending;
	logic [14:0] vec_base;
	logic [6:0] vec_high;
	logic pc_load;
	logic [14:0] pc_value;
	logic pmem_req;
	logic [14:0] pmem_addr;
	logic push;
	logic [14:0] push_addr;
	logic [7:0] wake_pending;

	// ==========================================================
	// Port-L lines
	// ==========================================================
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_line
			vira_edge_line u_line (
				.mclk_in(mclk_in),
				.reset_n_in(reset_n_in),
				.pin_in(port_l_in[g]),
				.falling_in(wake_edge_select_in[g]),
				.clear_in(wake_line_clear_in[g]),
				.hold_in(1'b0),
				.pending_out(wake_pending[g])
			);
		end
	endgenerate

	// ==========================================================
	// Activity and ranking
	// ==========================================================
	// Active maskable sources need enable and pending
	wire [6:0] src_active = src_pending_in & src_enable_in;
	wire [7:0] wake_active = wake_pending & wake_line_enable_in;
	wire wake_src = (|wake_active) & wake_irq_global_enable_in;
	// Reserved slots have no input at all
	wire [7:0] slot =
		trap_pending ? `VIRA_SLOT_TRAP :
		src_active[0] ? `VIRA_SLOT_EXT :
		src_active[1] ? `VIRA_SLOT_T0 :
		src_active[2] ? `VIRA_SLOT_T1A :
		src_active[3] ? `VIRA_SLOT_T1B :
		src_active[4] ? `VIRA_SLOT_SER :
		src_active[5] ? `VIRA_SLOT_T2A :
		src_active[6] ? `VIRA_SLOT_T2B :
		wake_src ? `VIRA_SLOT_WAKE :
		`VIRA_SLOT_DEFAULT;
	wire any_maskable = (|src_active) | wake_src;
	// Maskable request: global enable, no trap, not in boot ROM
	wire mask_req = any_maskable & global_irq_enable & ~trap_pending & ~boot_rom_in;
	// Trap: opcode 00 loaded (also what blank flash returns)
	wire trap_hit = ir_load_in & (ir_opcode_in == `VIRA_TRAP_OPCODE);
	wire idle_now = (state == vira_idle);
	wire start_mask = idle_now & mask_req & ir_load_in & ~trap_hit;
	wire start_trap = idle_now & trap_hit & ~boot_rom_in;
	// Vector table block, next block when select sits at xxFF
	wire [6:0] blk = pc_in[14:8];
	wire [6:0] blk_next = blk + 7'h01;
	wire [6:0] vec_blk = (pc_in[7:0] == 8'hFF) ? blk_next : blk;

	// ==========================================================
	// Trap pending flag and global enable
	// ==========================================================
	// Trap set beats clear in the same cycle
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			trap_pending <= 1'b0;
		end else begin
			if (start_trap) begin
				trap_pending <= 1'b1;
			end else if (clear_trap_pending_op_in) begin
				trap_pending <= 1'b0;
			end
		end
	end

	// Global enable: cleared on maskable acknowledge, set on return
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			global_irq_enable <= 1'b0;
		end else if (start_mask) begin
			global_irq_enable <= 1'b0;
		end else if (return_enable_op_in || set_gie_in) begin
			global_irq_enable <= 1'b1;
		end else if (clear_gie_in) begin
			global_irq_enable <= 1'b0;
		end
	end

	// ==========================================================
	// Sequencer decode
	// ==========================================================
	// One start per idle cycle: acknowledge, then return, then vector select
	wire go_ack = start_trap | start_mask;
	wire go_ret = idle_now & ~go_ack & return_enable_op_in;
	wire go_vis = idle_now & ~go_ack & ~return_enable_op_in & vector_select_op_in;
	wire ack_done = (state == vira_ack) & (ack_count == 3'h1);
	wire in_vec_hi = (state == vira_vec_hi);
	wire in_vec_lo = (state == vira_vec_lo);
	// Vector entry address: table block plus ranked slot, sampled in the first cycle
	wire [14:0] vec_addr = {vec_blk, slot};
	// Trap returns to itself, maskable to the next instruction
	wire [14:0] ack_push_addr = start_trap ? ir_addr_in : next_addr_in;
	// Full vector: high byte came first, its top bit dropped
	wire [14:0] vec_target = {vec_high, pmem_data_in};

	// Next state
	always_comb begin
		next_state = state;
		unique case (state)
			vira_idle: begin
				if (go_ack) begin
					next_state = vira_ack;
				end else if (go_vis) begin
					next_state = vira_vec_hi;
				end
			end
			vira_ack: begin
				if (ack_done) begin
					next_state = vira_idle;
				end
			end
			vira_vec_hi: begin
				next_state = vira_vec_lo;
			end
			vira_vec_lo: begin
				next_state = vira_ret;
			end
			vira_ret: begin
				next_state = vira_idle;
			end
			default: begin
				next_state = vira_idle;
			end
		endcase
	end

	// ==========================================================
	// Acknowledge and vector sequencer
	// ==========================================================
	// State and acknowledge cycle counter
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= vira_idle;
			ack_count <= 3'h0;
		end else begin
			state <= next_state;
			if (go_ack) begin
				ack_count <= `VIRA_ACK_CYCLES - 3'h1;
			end else if (state == vira_ack) begin
				ack_count <= ack_count - 3'h1;
			end
		end
	end

	// Program counter loads: slot, return, acknowledge target, vector
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pc_load <= 1'b0;
			pc_value <= `VIRA_RST_PC;
		end else begin
			pc_load <= go_vis | go_ret | ack_done | in_vec_lo;
			if (go_vis) begin
				pc_value <= vec_addr;
			end else if (go_ret) begin
				pc_value <= pop_addr_in;
			end else if (ack_done) begin
				pc_value <= `VIRA_ACK_PC;
			end else if (in_vec_lo) begin
				pc_value <= vec_target;
			end
		end
	end

	// Vector fetch requests; high byte sits at the lower address
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			vec_base <= `VIRA_RST_PC;
			vec_high <= 7'h00;
			pmem_req <= 1'b0;
			pmem_addr <= `VIRA_RST_PC;
		end else begin
			pmem_req <= go_vis | in_vec_hi;
			if (go_vis) begin
				vec_base <= vec_addr;
				pmem_addr <= vec_addr;
			end else if (in_vec_hi) begin
				vec_high <= pmem_data_in[6:0];
				pmem_addr <= vec_base + 15'h0001;
			end
		end
	end

	// Return address push on acknowledge
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			push <= 1'b0;
			push_addr <= `VIRA_RST_PC;
		end else begin
			push <= go_ack;
			if (go_ack) begin
				push_addr <= ack_push_addr;
			end
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Wake always; request service only if interrupt path enabled
	assign wake_out = halted_in & (|wake_active);
	assign resume_next_out = wake_out & ~(wake_src & global_irq_enable);
	assign global_irq_enable_out = global_irq_enable;
	assign trap_pending_flag_out = trap_pending;
	assign wake_line_pending_out = wake_pending;
	// Boot code blocks the trap request as well
	assign irq_request_out = mask_req | (trap_hit & ~boot_rom_in);
	assign ack_busy_out = ~idle_now;
	assign pc_load_out = pc_load;
	assign pc_value_out = pc_value;
	assign pmem_req_out = pmem_req;
	assign pmem_addr_out = pmem_addr;
	assign push_out = push;
	assign push_addr_out = push_addr;
	assign trap_fetch_out = trap_hit & outside_flash_in;
endmodule
`default_nettype wire

/* File: verification/vira_assertions.sv */
// Concurrent checks on the vectored interrupt arbiter top ports.
// Assumes a bind onto vira_top, every port connected by name.
`timescale 1ns/100ps
`default_nettype none
module vira_assertions (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic ir_load_in,
	input wire logic [7:0] ir_opcode_in,
	input wire logic [14:0] ir_addr_in,
	input wire logic vector_select_op_in,
	input wire logic clear_trap_pending_op_in,
	input wire logic set_gie_in,
	input wire logic clear_gie_in,
	input wire logic boot_rom_in,
	input wire logic [14:0] pc_in,
	input wire logic ack_busy_out,
	input wire logic global_irq_enable_out,
	input wire logic trap_pending_flag_out,
	input wire logic irq_request_out,
	input wire logic pc_load_out,
	input wire logic [14:0] pc_value_out,
	input wire logic pmem_req_out,
	input wire logic push_out,
	input wire logic [14:0] push_addr_out
);
	// ==========
	// Start conditions
	wire vis_go = vector_select_op_in && !ack_busy_out;
	wire trap_ld = ir_load_in && ir_opcode_in == 8'h00;
	wire trap_go = trap_ld && !boot_rom_in && !ack_busy_out;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	vis_slot_a: assert property (vis_go |=> pc_load_out && !pc_value_out[0]
		&& pc_value_out[7:5] == 3'h7) else $error("vector slot out of range");
	vis_block_a: assert property (vis_go && pc_in[7:0] != 8'hFF |=>
		pc_value_out[14:8] == $past(pc_in[14:8])) else $error("vector block changed");
	vis_fetch_a: assert property (vis_go |=> pmem_req_out ##1 pmem_req_out ##1 pc_load_out)
		else $error("vector fetch order wrong");
	trap_set_a: assert property (trap_go |=> trap_pending_flag_out)
		else $error("trap flag not set");
	trap_hold_a: assert property (trap_pending_flag_out && !clear_trap_pending_op_in |=>
		trap_pending_flag_out) else $error("trap flag lost");
	trap_gie_a: assert property (trap_go && !set_gie_in && !clear_gie_in |=>
		$stable(global_irq_enable_out)) else $error("trap touched global enable");
	trap_mask_a: assert property (trap_pending_flag_out && !trap_ld |-> !irq_request_out)
		else $error("maskable request under trap");
	boot_block_a: assert property (boot_rom_in |-> !irq_request_out)
		else $error("request during boot code");
	trap_ack_a: assert property (trap_go |=> push_out && push_addr_out == $past(ir_addr_in)
		##6 pc_load_out && pc_value_out == 15'h00FF) else $error("trap ack wrong");
	cover property (vis_go && pc_in[7:0] == 8'hFF);
	cover property (trap_go);
	cover property (ir_load_in && irq_request_out && !trap_ld);
endmodule
`default_nettype wire

/* File: verification/vira_pmem_model.sv */
// Program memory seen by the arbiter: byte stands while its request stands.
// Assumes requests are one-cycle pulses on mclk_in.
`timescale 1ns/100ps
`default_nettype none
module vira_pmem_model (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic req_in,
	input wire logic [14:0] addr_in,
	output logic [7:0] data_out
);
	logic [7:0] idle_pattern;
	// ==========
	// Changing pattern so a stale byte is never taken for data
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			idle_pattern <= 8'hA5;
		else
			idle_pattern <= ~idle_pattern;
	end
	// Byte answers the request in its own cycle; arbiter samples at the next edge
	assign data_out = req_in ? (addr_in[7:0] ^ 8'h5A) : idle_pattern;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for vira_top with a program memory model.
// Assumes the checker is bound onto the design below.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import vira_pkg::*;
	logic mclk_in = 1'h0, reset_n_in = 1'h0, ir_load_in, outside_flash_in, vector_select_op_in;
	logic clear_trap_pending_op_in, return_enable_op_in, set_gie_in, clear_gie_in, boot_rom_in;
	logic halted_in, wake_irq_global_enable_in, global_irq_enable_out, trap_pending_flag_out;
	logic irq_request_out, ack_busy_out, pc_load_out, pmem_req_out, push_out, trap_fetch_out;
	logic wake_out, resume_next_out;
	logic [7:0] ir_opcode_in, pmem_data_in, port_l_in, wake_line_enable_in, wake_edge_select_in;
	logic [7:0] wake_line_clear_in, wake_line_pending_out;
	logic [14:0] ir_addr_in, next_addr_in, pop_addr_in, pc_in, pc_value_out, pmem_addr_out;
	logic [14:0] push_addr_out;
	logic [6:0] src_pending_in, src_enable_in;
	int n_mismatch = 0, check_count = 0, cycles = 0;
	vira_top u_dut (.mclk_in, .reset_n_in, .ir_load_in, .ir_opcode_in, .ir_addr_in, .next_addr_in,
		.outside_flash_in, .vector_select_op_in, .clear_trap_pending_op_in, .return_enable_op_in,
		.pop_addr_in, .set_gie_in, .clear_gie_in, .boot_rom_in, .halted_in, .pc_in, .pmem_data_in,
		.src_pending_in, .src_enable_in, .port_l_in, .wake_line_enable_in, .wake_edge_select_in,
		.wake_line_clear_in, .wake_irq_global_enable_in, .global_irq_enable_out,
		.trap_pending_flag_out, .wake_line_pending_out, .irq_request_out, .ack_busy_out,
		.pc_load_out, .pc_value_out, .pmem_req_out, .pmem_addr_out, .push_out, .push_addr_out,
		.trap_fetch_out, .wake_out, .resume_next_out);
	vira_pmem_model u_mem (.mclk_in, .reset_n_in, .req_in(pmem_req_out),
		.addr_in(pmem_addr_out), .data_out(pmem_data_in));
	// ==========
	// Clock and hang limit
	initial forever #50 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic nx(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	// Vector select from pc, expecting the given slot and table block
	task automatic vector_select_op(input logic [14:0] pc, input logic [7:0] slot);
		logic [14:0] base;
		logic [7:0] hb, lb;
		base = {pc[14:8] + (pc[7:0] == 8'hFF), slot};
		hb = slot ^ 8'h5A;
		lb = (slot + 8'h01) ^ 8'h5A;
		pc_in = pc;
		vector_select_op_in = 1'h1;
		nx(1);
		vector_select_op_in = 1'h0;
		chk(pc_value_out, base);
		nx(2);
		chk(pc_value_out, {hb[6:0], lb});
		nx(1);
	endtask
	task automatic t_rank();
		logic [7:0] slot [7] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hEA, 8'hE8};
		src_enable_in = 7'h7F;
		for (int i = 0; i < 7; i++) begin
			src_pending_in = 7'h7F << i;
			vector_select_op(15'h0123, slot[i]);
		end
		src_enable_in = 7'h00;
		vector_select_op(15'h01FF, 8'hE0);
		src_pending_in = 7'h00;
	endtask
	task automatic t_wake();
		wake_line_enable_in = 8'h03;
		wake_edge_select_in = 8'h02;
		wake_irq_global_enable_in = 1'h1;
		port_l_in = 8'h02;
		nx(2);
		chk(wake_line_pending_out, 8'h00);
		port_l_in = 8'h01;
		nx(2);
		chk(wake_line_pending_out, 8'h03);
		halted_in = 1'h1;
		#1 chk(wake_out, 1'h1);
		chk(resume_next_out, 1'h1);
		set_gie_in = 1'h1;
		nx(1);
		set_gie_in = 1'h0;
		chk(resume_next_out, 1'h0);
		{halted_in, clear_gie_in} = 2'h1;
		nx(1);
		clear_gie_in = 1'h0;
		vector_select_op(15'h0234, 8'hE2);
		wake_line_clear_in = 8'hFF;
		nx(1);
		wake_line_clear_in = 8'h00;
		nx(1);
		chk(wake_line_pending_out, 8'h00);
	endtask
	task automatic t_irq();
		set_gie_in = 1'h1;
		nx(1);
		set_gie_in = 1'h0;
		src_enable_in = 7'h01;
		src_pending_in = 7'h01;
		boot_rom_in = 1'h1;
		nx(1);
		chk(irq_request_out, 1'h0);
		boot_rom_in = 1'h0;
		nx(1);
		chk(irq_request_out, 1'h1);
		{next_addr_in, ir_opcode_in, ir_load_in} = {15'h0456, 8'hA5, 1'h1};
		nx(1);
		ir_load_in = 1'h0;
		chk(push_addr_out, 15'h0456);
		chk(push_out, 1'h1);
		chk(global_irq_enable_out, 1'h0);
		nx(6);
		chk(pc_value_out, 15'h00FF);
		chk(pc_load_out, 1'h1);
		{src_pending_in, pop_addr_in, return_enable_op_in} = {7'h00, 15'h0456, 1'h1};
		nx(1);
		return_enable_op_in = 1'h0;
		chk(global_irq_enable_out, 1'h1);
		chk(pc_value_out, 15'h0456);
	endtask
	task automatic t_trap();
		{outside_flash_in, ir_opcode_in, ir_addr_in, ir_load_in} = {1'h1, 8'h00, 15'h1F00, 1'h1};
		#1 chk(trap_fetch_out, 1'h1);
		nx(1);
		{outside_flash_in, ir_load_in, src_pending_in} = {1'h0, 1'h0, 7'h01};
		chk(push_addr_out, 15'h1F00);
		chk(trap_pending_flag_out, 1'h1);
		chk(global_irq_enable_out, 1'h1);
		nx(7);
		chk(irq_request_out, 1'h0);
		{ir_opcode_in, ir_load_in} = {8'hA5, 1'h1};
		nx(1);
		ir_load_in = 1'h0;
		chk(push_out, 1'h0);
		vector_select_op(15'h0123, 8'hFE);
		clear_trap_pending_op_in = 1'h1;
		nx(1);
		clear_trap_pending_op_in = 1'h0;
		chk(trap_pending_flag_out, 1'h0);
		chk(irq_request_out, 1'h1);
	endtask
	// ==========
	// Main sequence
	initial begin
		{ir_load_in, outside_flash_in, vector_select_op_in, clear_trap_pending_op_in} = '0;
		{return_enable_op_in, set_gie_in, clear_gie_in, boot_rom_in, halted_in} = '0;
		{wake_irq_global_enable_in, ir_opcode_in, port_l_in, wake_line_enable_in} = '0;
		{wake_edge_select_in, wake_line_clear_in, ir_addr_in, next_addr_in} = '0;
		{pop_addr_in, pc_in, src_pending_in, src_enable_in} = '0;
		nx(2);
		reset_n_in = 1'h1;
		nx(1);
		t_rank();
		t_wake();
		t_irq();
		t_trap();
		give_verdict();
	end
endmodule
bind vira_top vira_assertions u_chk (.mclk_in, .reset_n_in, .ir_load_in, .ir_opcode_in,
	.ir_addr_in, .vector_select_op_in, .clear_trap_pending_op_in, .set_gie_in, .clear_gie_in,
	.boot_rom_in, .pc_in, .ack_busy_out, .global_irq_enable_out, .trap_pending_flag_out,
	.irq_request_out, .pc_load_out, .pc_value_out, .pmem_req_out, .push_out, .push_addr_out);
`default_nettype wire
